// >>> design/low_counter.sv
// Saturating counter of consecutive low samples
`timescale 1ns/1ps
module low_counter (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       ce_i,
  // Level to measure
  input  wire logic       low_i,
  output logic            done_o
);
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  // Saturate so a long low never wraps back to invalid
  always_comb begin
    cnt_nxt = cnt_r;
    if (!low_i) begin
      cnt_nxt = 5'h00;
    end else if (cnt_r != rst_init_pkg::LOW_CNT_MAX) begin
      cnt_nxt = cnt_r + 5'h01;
    end
  end
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_r <= 5'h00;
    end else if (ce_i) begin
      cnt_r <= cnt_nxt;
    end
  end
  assign done_o = (cnt_r == rst_init_pkg::LOW_CNT_MAX);
endmodule

// >>> design/mcu_reset_init.sv
// Reset qualifier, vector fetch and initial register state with APB view
//
// Summary of operation
// - Program counter loaded from FFFD high, FFFC low
// - Port data and direction cleared to zero
// - Timers and prescalers all ones except timer1, modes zero
// - Prescaler12 ones, timer1 one, timer2 ones
// - All pull-up controls cleared to zero
// - Both conversion data registers cleared
// - Interrupt request, control, select, edge cleared
// - Count-source selects load pattern 00110011
// - Other registers and RAM left undefined
// - Only main oscillator runs; sub pins are ports
// - Middle-speed mode, clock divided by eight
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ps
module mcu_reset_init (
  // Clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        ce_i,
  // External reset pin, active low
  input  wire logic        reset_pin_n_i,
  // Vector memory read port
  output logic [15:0]      vec_addr_o,
  output logic             vec_rd_o,
  input  wire logic [7:0]  vec_data_i,
  // Core control
  output logic             core_rst_o,
  output logic             fetch_start_o,
  output logic [15:0]      pc_o,
  output logic [1:0]       speed_mode_o,
  output logic             phi_o,
  // Oscillators and sub-clock pins
  output logic             main_osc_en_o,
  output logic             sub_osc_en_o,
  output logic             sub_pins_gpio_o,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o
);
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    rst_init_pkg::seq_state_t st;
    logic                     core_rst;
    logic                     fetch_start;
    logic                     vec_rd;
    logic [15:0]              vec_addr;
    logic [15:0]              pc;
    logic [1:0]               speed;
    logic [2:0]               div;
    logic                     phi;
    logic                     sub_en;
    logic                     main_en;
    logic                     sub_gpio;
    logic [7:0]               pre12;
    logic [7:0]               t1;
    logic [7:0]               t2;
    logic [7:0]               prex;
    logic [7:0]               tx;
    logic [7:0]               prey;
    logic [7:0]               ty;
    logic [7:0]               tzl;
    logic [7:0]               tzh;
    logic [7:0]               tm;
    logic [7:0]               tzm;
    logic [7:0]               css12x;
    logic [7:0]               cssyz;
    logic [7:0]               da1;
    logic [7:0]               da2;
    logic [7:0]               ireq1;
    logic [7:0]               ireq2;
    logic [7:0]               icon1;
    logic [7:0]               icon2;
    logic [7:0]               intsel;
    logic [7:0]               intedge;
    logic [2:0]               port_sel;
    logic [31:0]              prdata;
    logic                     pready;
    logic                     pslverr;
  } state_t;

  typedef struct packed {
    logic [7:0] dat;
    logic [7:0] dir;
    logic [7:0] pull;
  } port_t;

  state_t s_r;
  state_t s_nxt;
  port_t  ports_r   [rst_init_pkg::NUM_PORTS];
  port_t  ports_nxt [rst_init_pkg::NUM_PORTS];

  logic pin_s;
  logic low_done;
  logic pin_low;

  // ----------------------------------------------------------------
  // Pin qualification
  // ----------------------------------------------------------------
  // Pin is treated as synchronous but still double-flopped for safety
  pin_sync u_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .ce_i      (ce_i),
    .d_i       (reset_pin_n_i),
    .q_o       (pin_s)
  );
  assign pin_low = ~pin_s;

  low_counter u_cnt (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .ce_i      (ce_i),
    .low_i     (pin_low),
    .done_o    (low_done)
  );

  // ----------------------------------------------------------------
  // APB decode helpers
  // ----------------------------------------------------------------
  logic apb_acc;
  logic apb_wr;
  assign apb_acc = psel_i & penable_i & ~s_r.pready;
  assign apb_wr  = psel_i & penable_i & s_r.pready & pwrite_i;  // Lands on the completing edge

  // ----------------------------------------------------------------
  // Port registers, one entry per port
  // ----------------------------------------------------------------
  // Ports share one indirect window to keep the map small
  genvar gi;
  generate
    for (gi = 0; gi < rst_init_pkg::NUM_PORTS; gi++) begin : g_port
      always_comb begin
        ports_nxt[gi] = ports_r[gi];
        if (s_r.core_rst) begin
          ports_nxt[gi].dat  = rst_init_pkg::ZERO_VAL;
          ports_nxt[gi].dir  = rst_init_pkg::ZERO_VAL;
          ports_nxt[gi].pull = rst_init_pkg::ZERO_VAL;
        end else if (apb_wr && paddr_i == rst_init_pkg::ADDR_PORTDAT &&
                     s_r.port_sel == 3'(gi)) begin
          ports_nxt[gi].dat  = pwdata_i[7:0];
          ports_nxt[gi].dir  = pwdata_i[15:8];
          ports_nxt[gi].pull = pwdata_i[23:16];
        end
      end
      always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          ports_r[gi] <= '0;
        end else if (ce_i) begin
          ports_r[gi] <= ports_nxt[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Sequencer, register file and bus answers
  // ----------------------------------------------------------------
  always_comb begin
    port_t sel_port;
    sel_port      = '0;
    s_nxt         = s_r;                                // Unlisted fields hold
    s_nxt.fetch_start = 1'b0;
    s_nxt.vec_rd  = 1'b0;
    s_nxt.pready  = 1'b0;
    s_nxt.pslverr = 1'b0;
    if (s_r.port_sel < 3'(rst_init_pkg::NUM_PORTS)) begin
      sel_port = ports_r[s_r.port_sel];
    end
    case (s_r.st)
      rst_init_pkg::ST_RESET: begin
        s_nxt.core_rst = 1'b1;
        if (low_done) begin
          s_nxt.st = rst_init_pkg::ST_QUAL;
        end
      end
      rst_init_pkg::ST_QUAL: begin
        s_nxt.core_rst = 1'b1;
        // Release only on return high after a valid low
        if (pin_s) begin
          s_nxt.st       = rst_init_pkg::ST_VECHI;
          s_nxt.vec_addr = rst_init_pkg::VEC_HI_ADDR;
          s_nxt.vec_rd   = 1'b1;
        end
      end
      rst_init_pkg::ST_VECHI: begin
        s_nxt.pc[15:8] = vec_data_i;
        s_nxt.vec_addr = rst_init_pkg::VEC_LO_ADDR;
        s_nxt.vec_rd   = 1'b1;
        s_nxt.st       = rst_init_pkg::ST_VECLO;
      end
      rst_init_pkg::ST_VECLO: begin
        s_nxt.pc[7:0]     = vec_data_i;
        s_nxt.core_rst    = 1'b0;
        s_nxt.fetch_start = 1'b1;
        s_nxt.st          = rst_init_pkg::ST_RUN;
      end
      rst_init_pkg::ST_RUN: begin
        if (pin_low) begin
          s_nxt.st       = rst_init_pkg::ST_RESET;
          s_nxt.core_rst = 1'b1;
        end
      end
      default: begin
        s_nxt.st       = rst_init_pkg::ST_RESET;
        s_nxt.core_rst = 1'b1;
      end
    endcase
    // Internal reset loads the documented initial values
    if (s_r.core_rst) begin
      s_nxt.speed   = rst_init_pkg::MID_SPEED_MODE;
      s_nxt.sub_en  = 1'b0;
      s_nxt.sub_gpio = 1'b1;
      s_nxt.pre12   = rst_init_pkg::ONES_VAL;
      s_nxt.t1      = rst_init_pkg::TIMER1_RST;
      s_nxt.t2      = rst_init_pkg::ONES_VAL;
      s_nxt.prex    = rst_init_pkg::ONES_VAL;
      s_nxt.tx      = rst_init_pkg::ONES_VAL;
      s_nxt.prey    = rst_init_pkg::ONES_VAL;
      s_nxt.ty      = rst_init_pkg::ONES_VAL;
      s_nxt.tzl     = rst_init_pkg::ONES_VAL;
      s_nxt.tzh     = rst_init_pkg::ONES_VAL;
      s_nxt.tm      = rst_init_pkg::ZERO_VAL;
      s_nxt.tzm     = rst_init_pkg::ZERO_VAL;
      s_nxt.css12x  = rst_init_pkg::CSS_RST;
      s_nxt.cssyz   = rst_init_pkg::CSS_RST;
      s_nxt.da1     = rst_init_pkg::ZERO_VAL;
      s_nxt.da2     = rst_init_pkg::ZERO_VAL;
      s_nxt.ireq1   = rst_init_pkg::ZERO_VAL;
      s_nxt.ireq2   = rst_init_pkg::ZERO_VAL;
      s_nxt.icon1   = rst_init_pkg::ZERO_VAL;
      s_nxt.icon2   = rst_init_pkg::ZERO_VAL;
      s_nxt.intsel  = rst_init_pkg::ZERO_VAL;
      s_nxt.intedge = rst_init_pkg::ZERO_VAL;
    end
    // Phi divider: main oscillator over 8 in middle speed, 2 otherwise
    if (s_r.core_rst) begin
      s_nxt.div = 3'h0;
      s_nxt.phi = 1'b0;
    end else begin
      s_nxt.div = s_r.div + 3'h1;
      if (s_r.speed == rst_init_pkg::MID_SPEED_MODE) begin
        s_nxt.phi = s_r.div[2];
      end else begin
        s_nxt.phi = s_r.div[0];
      end
    end
    // APB: one wait state, answer one cycle after access begins
    if (apb_acc) begin
      s_nxt.pready = 1'b1;
      s_nxt.prdata = 32'h0000_0000;
      case (paddr_i)
        rst_init_pkg::ADDR_STATUS: begin
          s_nxt.prdata = {26'h0, s_r.sub_en, s_r.core_rst, s_r.st[4:1]};
        end
        rst_init_pkg::ADDR_PC: begin
          s_nxt.prdata = {16'h0, s_r.pc};
        end
        rst_init_pkg::ADDR_TIMERS: begin
          s_nxt.prdata = {s_r.prex, s_r.t2, s_r.t1, s_r.pre12};
        end
        rst_init_pkg::ADDR_TIMERS2: begin
          s_nxt.prdata = {s_r.tzh, s_r.tzl, s_r.ty, s_r.prey};
        end
        rst_init_pkg::ADDR_CONTROL: begin
          s_nxt.prdata = {s_r.cssyz, s_r.css12x, s_r.tzm, s_r.tm};
        end
        rst_init_pkg::ADDR_PORTSEL: begin
          s_nxt.prdata = {29'h0, s_r.port_sel};
        end
        rst_init_pkg::ADDR_PORTDAT: begin
          s_nxt.prdata = {8'h00, sel_port.pull, sel_port.dir, sel_port.dat};
        end
        rst_init_pkg::ADDR_MISC: begin
          s_nxt.prdata = {s_r.intedge, s_r.intsel, s_r.da2, s_r.da1};
        end
        default: begin
          s_nxt.pslverr = 1'b1;
        end
      endcase
    end
    // Writes land only at the edge that completes the transfer
    if (apb_wr) begin
      case (paddr_i)
        rst_init_pkg::ADDR_CONTROL: begin
          if (!s_r.core_rst) begin
            s_nxt.tm     = pwdata_i[7:0];
            s_nxt.tzm    = pwdata_i[15:8];
            s_nxt.css12x = pwdata_i[23:16];
            s_nxt.cssyz  = pwdata_i[31:24];
          end
        end
        rst_init_pkg::ADDR_PORTSEL: begin
          s_nxt.port_sel = pwdata_i[2:0];
        end
        rst_init_pkg::ADDR_MISC: begin
          if (!s_r.core_rst) begin
            s_nxt.da1     = pwdata_i[7:0];
            s_nxt.da2     = pwdata_i[15:8];
            s_nxt.intsel  = pwdata_i[23:16];
            s_nxt.intedge = pwdata_i[31:24];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Single register stage for all state except the port registers
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_r          <= '0;
      s_r.st       <= rst_init_pkg::ST_RESET;
      s_r.core_rst <= 1'b1;
      s_r.speed    <= rst_init_pkg::MID_SPEED_MODE;
      s_r.main_en  <= 1'b1;
      s_r.sub_gpio <= 1'b1;
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all from flip-flops
  // ----------------------------------------------------------------
  assign core_rst_o      = s_r.core_rst;
  assign fetch_start_o   = s_r.fetch_start;
  assign vec_addr_o      = s_r.vec_addr;
  assign vec_rd_o        = s_r.vec_rd;
  assign pc_o            = s_r.pc;
  assign speed_mode_o    = s_r.speed;
  assign phi_o           = s_r.phi;
  assign main_osc_en_o   = s_r.main_en;
  assign sub_osc_en_o    = s_r.sub_en;
  assign sub_pins_gpio_o = s_r.sub_gpio;
  assign prdata_o        = s_r.prdata;
  assign pready_o        = s_r.pready;
  assign pslverr_o       = s_r.pslverr;
endmodule

// >>> design/pin_sync.sv
// Two-stage synchroniser with clock enable and preset value
`timescale 1ns/1ps
module pin_sync (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic ce_i,
  // Pin in, level out
  input  wire logic d_i,
  output logic      q_o
);
  logic [1:0] sync_r;
  // First stage feeds only the second; reset reads as pin low
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync_r <= 2'h0;
    end else if (ce_i) begin
      sync_r <= {sync_r[0], d_i};
    end
  end
  assign q_o = sync_r[1];
endmodule

// >>> design/rst_init_pkg.sv
// Constants for the reset qualifier and initial-state loader
package rst_init_pkg;
  // ----------------------------------------------------------------
  // Qualification and vector fetch
  // ----------------------------------------------------------------
  localparam int unsigned MIN_LOW_CYCLES = 16;
  localparam logic [4:0]  LOW_CNT_MAX    = 5'h10;
  localparam logic [15:0] VEC_HI_ADDR    = 16'hFFFD;
  localparam logic [15:0] VEC_LO_ADDR    = 16'hFFFC;
  localparam logic [1:0]  MID_SPEED_MODE = 2'h2;
  localparam logic [2:0]  MID_SPEED_DIV  = 3'h7;
  // ----------------------------------------------------------------
  // Register values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0]  ZERO_VAL       = 8'h00;
  localparam logic [7:0]  ONES_VAL       = 8'hFF;
  localparam logic [7:0]  TIMER1_RST     = 8'h01;
  localparam logic [7:0]  CSS_RST        = 8'h33;
  localparam int unsigned NUM_PORTS      = 7;
  // ----------------------------------------------------------------
  // APB register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADDR_STATUS    = 8'h00;
  localparam logic [7:0]  ADDR_PC        = 8'h04;
  localparam logic [7:0]  ADDR_TIMERS    = 8'h08;
  localparam logic [7:0]  ADDR_TIMERS2   = 8'h0C;
  localparam logic [7:0]  ADDR_CONTROL   = 8'h10;
  localparam logic [7:0]  ADDR_PORTSEL   = 8'h14;
  localparam logic [7:0]  ADDR_PORTDAT   = 8'h18;
  localparam logic [7:0]  ADDR_MISC      = 8'h1C;
  // Sequencer states
  typedef enum logic [4:0] {
    ST_RESET = 5'b00001,
    ST_QUAL  = 5'b00010,
    ST_VECHI = 5'b00100,
    ST_VECLO = 5'b01000,
    ST_RUN   = 5'b10000
  } seq_state_t;
endpackage

// >>> test/mcu_reset_init_assertions.sv
// Port checker for the reset qualifier and vector fetch
`timescale 1ns/1ps
module mcu_reset_init_checker (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  // Pin and vector port
  input wire logic        reset_pin_n_i,
  input wire logic [15:0] vec_addr_o,
  input wire logic        vec_rd_o,
  input wire logic [7:0]  vec_data_i,
  // Core side
  input wire logic        core_rst_o,
  input wire logic        fetch_start_o,
  input wire logic [15:0] pc_o,
  input wire logic [1:0]  speed_mode_o,
  input wire logic        phi_o,
  input wire logic        main_osc_en_o,
  input wire logic        sub_osc_en_o,
  input wire logic        sub_pins_gpio_o,
  // APB
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic [7:0]  paddr_i,
  input wire logic        pready_o,
  input wire logic        pslverr_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // ----------------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------------
  logic [5:0] low_run_r;
  logic [5:0] last_run_r;
  logic [7:0] hi_r;
  logic [7:0] lo_r;
  // Raw pin low run, saturating so a long power-on hold never wraps
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      low_run_r  <= 6'h00;
      last_run_r <= 6'h00;
      hi_r       <= 8'h00;
      lo_r       <= 8'h00;
    end else begin
      low_run_r <= reset_pin_n_i ? 6'h00 : low_run_r + {5'h00, low_run_r != 6'h3F};
      if (reset_pin_n_i && low_run_r != 6'h00) last_run_r <= low_run_r;
      if (vec_rd_o && vec_addr_o == 16'hFFFD) hi_r <= vec_data_i;
      if (vec_rd_o && vec_addr_o == 16'hFFFC) lo_r <= vec_data_i;
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_qual_min: assert property ($rose(vec_rd_o) |-> last_run_r >= 6'h10)
    else $error("vector fetch after a short low pulse");
  a_vec_order: assert property (vec_rd_o && vec_addr_o == 16'hFFFD |=>
    vec_rd_o && vec_addr_o == 16'hFFFC) else $error("low vector byte not fetched next");
  a_fetch_after: assert property ($rose(fetch_start_o) |->
    $past(vec_rd_o) && $past(vec_addr_o) == 16'hFFFC) else $error("fetch before vectors");
  a_release_fetch: assert property ($fell(core_rst_o) |-> fetch_start_o)
    else $error("core reset fell without fetch start");
  a_pc_vector: assert property (fetch_start_o |-> pc_o == {hi_r, lo_r})
    else $error("pc differs from vector bytes");
  a_rst_restart: assert property (!reset_pin_n_i [*5] |-> core_rst_o)
    else $error("core reset low while pin held low");
  a_speed_mid: assert property (speed_mode_o == rst_init_pkg::MID_SPEED_MODE)
    else $error("speed mode not middle speed");
  a_phi_div: assert property (disable iff (sys_rst_i || core_rst_o)
    $changed(phi_o) |=> $stable(phi_o) [*3] ##1 $changed(phi_o))
    else $error("phi not divided by eight");
  a_osc_main: assert property (main_osc_en_o && !sub_osc_en_o && sub_pins_gpio_o)
    else $error("oscillator state wrong");
  a_apb_wait: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("apb answer late");
  a_apb_err: assert property (psel_i && penable_i && pready_o && paddr_i > 8'h1C |-> pslverr_o)
    else $error("unmapped access not refused");
  // Main scenarios
  c_fetch: cover property (fetch_start_o);
  c_err: cover property (psel_i && penable_i && pready_o && pslverr_o);
  c_restart: cover property ($rose(core_rst_o));
endmodule

bind mcu_reset_init mcu_reset_init_checker u_chk (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reset_pin_n_i(reset_pin_n_i),
  .vec_addr_o(vec_addr_o), .vec_rd_o(vec_rd_o), .vec_data_i(vec_data_i),
  .core_rst_o(core_rst_o), .fetch_start_o(fetch_start_o), .pc_o(pc_o),
  .speed_mode_o(speed_mode_o), .phi_o(phi_o), .main_osc_en_o(main_osc_en_o),
  .sub_osc_en_o(sub_osc_en_o), .sub_pins_gpio_o(sub_pins_gpio_o), .psel_i(psel_i),
  .penable_i(penable_i), .paddr_i(paddr_i), .pready_o(pready_o), .pslverr_o(pslverr_o)
);

// >>> test/mcu_reset_init_test.sv
// Self-checking bench for the reset qualifier and initial-state loader
`timescale 1ns/1ps
module mcu_reset_init_test;
  // Stimulus and observed signals
  logic        clk_i = 1'b0, sys_rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0;
  logic        pwrite_i = 1'b0, reset_pin_n_i, vec_rd_o, core_rst_o, fetch_start_o, phi_o;
  logic        main_osc_en_o, sub_osc_en_o, sub_pins_gpio_o, pready_o, pslverr_o, err;
  logic [7:0]  paddr_i = 8'h00, vec_hi = 8'h00, vec_lo = 8'h00, vec_data_i;
  logic [15:0] vec_addr_o, pc_o;
  logic [1:0]  speed_mode_o;
  logic [31:0] pwdata_i = 32'h00000000, prdata_o, rd, lfsr = 32'h00008B96;
  // Model of the writable registers
  logic [31:0] m_ctl, m_misc, m_port [7];
  int          n_fail = 0, checks = 0, cycles = 0;

  always #25 clk_i = ~clk_i;

  mcu_reset_init DUT (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1), .reset_pin_n_i(reset_pin_n_i),
    .vec_addr_o(vec_addr_o), .vec_rd_o(vec_rd_o), .vec_data_i(vec_data_i),
    .core_rst_o(core_rst_o), .fetch_start_o(fetch_start_o), .pc_o(pc_o),
    .speed_mode_o(speed_mode_o), .phi_o(phi_o), .main_osc_en_o(main_osc_en_o),
    .sub_osc_en_o(sub_osc_en_o), .sub_pins_gpio_o(sub_pins_gpio_o), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o));
  reset_supervisor u_sup (
    .clk_i(clk_i), .reset_pin_n_o(reset_pin_n_i), .vec_addr_i(vec_addr_o),
    .vec_hi_i(vec_hi), .vec_lo_i(vec_lo), .vec_data_o(vec_data_i));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp, input string s);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h want %h", $time, s, got, exp);
    end
  endtask
  task automatic cmp_flag(input logic got, input logic exp, input string s);
    cmp_reg({31'h00000000, got}, {31'h00000000, exp}, s);
  endtask
  // One APB transfer: setup, then access held until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i   <= 1'b1;
    pwrite_i <= wr;
    paddr_i  <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic rd_cmp(input logic [7:0] a, input logic [31:0] exp, input string s);
    apb(1'b0, a, 32'h00000000);
    cmp_reg(rd, exp, s);
  endtask
  task automatic model_reset();
    m_ctl = {rst_init_pkg::CSS_RST, rst_init_pkg::CSS_RST, 16'h0000};
    m_misc = 32'h00000000;
    foreach (m_port[i]) m_port[i] = 32'h00000000;
  endtask
  // Readable state except status and PC against the model
  task automatic check_all();
    rd_cmp(rst_init_pkg::ADDR_TIMERS, 32'hFFFF01FF, "timers");
    rd_cmp(rst_init_pkg::ADDR_TIMERS2, 32'hFFFFFFFF, "timers2");
    rd_cmp(rst_init_pkg::ADDR_CONTROL, m_ctl, "control");
    rd_cmp(rst_init_pkg::ADDR_MISC, m_misc, "misc");
    for (int p = 0; p < 7; p++) begin
      apb(1'b1, rst_init_pkg::ADDR_PORTSEL, 32'(p));
      rd_cmp(rst_init_pkg::ADDR_PORTDAT, m_port[p], "port");
    end
    rd_cmp(rst_init_pkg::ADDR_PORTSEL, 32'h00000006, "port select");
  endtask
  // Bounded wait for the first fetch, then the vector it starts from
  task automatic wait_release(input logic [15:0] pc);
    int n;
    n = 0;
    while (fetch_start_o !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    cmp_flag(fetch_start_o, 1'b1, "fetch start");
    cmp_flag(core_rst_o, 1'b0, "core reset");
    cmp_reg({16'h0000, pc_o}, {16'h0000, pc}, "pc out");
  endtask
  task automatic new_vector();
    lfsr = nxt(lfsr);
    vec_hi <= lfsr[15:8];
    vec_lo <= lfsr[7:0];
  endtask

  // Hang guard, well above the length of the sequence
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      $display("unexpected at %0t: timeout", $time);
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    model_reset();
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    check_all();
    apb(1'b1, rst_init_pkg::ADDR_CONTROL, 32'h12345678);
    rd_cmp(rst_init_pkg::ADDR_CONTROL, m_ctl, "control held in reset");
    apb(1'b0, 8'h20, 32'h00000000);
    cmp_flag(err, 1'b1, "unmapped read");
    cmp_flag(core_rst_o, 1'b1, "hold while pin low");
    $display("test reset values done");
    new_vector();
    u_sup.power_on(16);
    wait_release(lfsr[15:0]);
    rd_cmp(rst_init_pkg::ADDR_PC, {16'h0000, lfsr[15:0]}, "pc reg");
    rd_cmp(rst_init_pkg::ADDR_STATUS, 32'h00000008, "status run");
    cmp_reg({30'h00000000, speed_mode_o}, 32'h00000002, "speed");
    cmp_flag(sub_osc_en_o, 1'b0, "sub osc");
    cmp_flag(sub_pins_gpio_o, 1'b1, "sub pins");
    $display("test power-on release done");
    lfsr = nxt(lfsr);
    m_ctl = lfsr;
    apb(1'b1, rst_init_pkg::ADDR_CONTROL, m_ctl);
    lfsr = nxt(lfsr);
    m_misc = lfsr;
    apb(1'b1, rst_init_pkg::ADDR_MISC, m_misc);
    for (int p = 0; p < 7; p++) begin
      lfsr = nxt(lfsr);
      m_port[p] = {8'h00, lfsr[23:0]};
      apb(1'b1, rst_init_pkg::ADDR_PORTSEL, 32'(p));
      apb(1'b1, rst_init_pkg::ADDR_PORTDAT, m_port[p]);
    end
    apb(1'b1, 8'h24, 32'hFFFFFFFF);
    cmp_flag(err, 1'b1, "unmapped write");
    check_all();
    $display("test register access done");
    u_sup.stable_pulse(15);
    repeat (40) @(posedge clk_i);
    #1;
    cmp_flag(core_rst_o, 1'b1, "short pulse kept reset");
    $display("test short pulse done");
    new_vector();
    u_sup.stable_pulse(16);
    wait_release(lfsr[15:0]);
    model_reset();
    check_all();
    $display("test pin reset done");
    end_of_test();
  end
endmodule

// >>> test/reset_supervisor.sv
// External reset source and vector memory facing the reset block
`timescale 1ns/1ps
module reset_supervisor #(
  parameter int unsigned SUPPLY_SETTLE_WAIT = 8 // Settle interval in clock cycles
) (
  // Clock
  input  wire logic        clk_i,
  // Reset pin, active low
  output logic             reset_pin_n_o,
  // Vector memory
  input  wire logic [15:0] vec_addr_i,
  input  wire logic [7:0]  vec_hi_i,
  input  wire logic [7:0]  vec_lo_i,
  output logic [7:0]       vec_data_o
);
  logic [7:0] last_r = 8'h00;
  // Pin low from time zero while the supply ramps
  initial reset_pin_n_o = 1'b0;
  // Settle, then n low cycles, then release
  task automatic power_on(input int n);
    repeat (SUPPLY_SETTLE_WAIT + n) @(posedge clk_i);
    reset_pin_n_o <= 1'b1;
  endtask
  // Stable supply: low, n cycles, high
  task automatic stable_pulse(input int n);
    @(posedge clk_i);
    reset_pin_n_o <= 1'b0;
    repeat (n) @(posedge clk_i);
    reset_pin_n_o <= 1'b1;
  endtask
  // Off the vector addresses the bus shows the inverse of its last value
  always_comb begin
    if (vec_addr_i == 16'hFFFD) vec_data_o = vec_hi_i;
    else if (vec_addr_i == 16'hFFFC) vec_data_o = vec_lo_i;
    else vec_data_o = ~last_r;
  end
  always_ff @(posedge clk_i) begin
    last_r <= vec_data_o;
  end
endmodule
